/* File: wdg_pkg.sv */
package wdg_pkg;
  // ==========================================
  // Register offsets
  localparam logic [11:0] CON0_OFS = 12'h000;
  localparam logic [11:0] CON1_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;
  localparam logic [11:0] IRQS_OFS = 12'h00C;
  localparam logic [11:0] IRQM_OFS = 12'h010;
  localparam logic [11:0] PMOD_OFS = 12'h014;
  // ==========================================
  // Control word fields
  localparam int LOCK_BIT = 0;
  localparam int GUARD_BIT = 1;
  localparam int PW_LSB = 2;
  localparam int PW_MSB = 15;
  localparam int RLD_LSB = 16;
  localparam int FIX_PW_BITS = 8;
  localparam logic [7:0] FIX_PW = 8'h3C;
  localparam logic [5:0] USR_PW_RST = 6'h00;
  localparam logic [15:0] RLD_RST = 16'hFFFC;
  localparam logic [15:0] FIX_RLD = 16'hFFFC;
  localparam logic [15:0] WAKE_FROM = 16'h7FFF;
  localparam logic [15:0] WAKE_TO = 16'h8000;
  // Control register 1 fields
  localparam int DIS_BIT = 0;
  localparam int SLOW_BIT = 1;
  // ==========================================
  // Timing
  localparam int DIV_FAST = 256;
  localparam int DIV_SLOW = 16384;
  localparam int ACC_WIN_CYC = 4;
  // Interrupt status bits
  localparam int EV_ACC = 0;
  localparam int EV_OVF = 1;
  localparam int EV_PRE = 2;
  localparam int EV_WAKE = 3;
  localparam int NEV = 4;
  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_SLEEP} wdg_pm_t;
  typedef struct packed {
    logic [11:0] addr;
    logic        wr;
    logic [31:0] wdata;
  } wdg_req_t;
endpackage

/* File: wdg_div.sv */
`timescale 1ns/100ps
module wdg_div
  import wdg_pkg::*;
#(
  parameter int SLOW = DIV_SLOW,
  parameter int FAST = DIV_FAST
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sel_slow,
  output logic o_tick
);
  localparam int W = $clog2(SLOW);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] lim;
  if (FAST < 2 || SLOW <= FAST) begin : g_bad_div
    $error("wdg_div: bad divider values");
  end
  assign lim = i_sel_slow ? W'(SLOW - 1) : W'(FAST - 1);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= '0;
      o_tick <= 1'b0;
    end else if (cnt_ff >= lim) begin
      cnt_ff <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule

/* File: wdg_unit.sv */
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/100ps
module wdg_unit
  import wdg_pkg::*;
#(
  parameter int SLOW_DIV = DIV_SLOW,
  parameter int FAST_DIV = DIV_FAST
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // System side
  input wire logic I_SUPERVISOR,
  input wire logic I_NMI_PIN,
  input wire logic I_IRQ_PEND,
  output logic O_PROT_WR_OK,
  output logic O_LOCK,
  output logic O_NMI,
  output logic O_SYS_RST,
  output logic O_WAKE,
  output logic O_IRQ
);
  // ==========================================
  // Bus decode
  wdg_req_t req;
  logic acc;
  logic wr_en;
  logic [11:0] ofs;
  logic mapped;
  assign req = '{addr: I_PADDR, wr: I_PWRITE, wdata: I_PWDATA};
  assign acc = I_PSEL && I_PENABLE && !O_PREADY;
  assign wr_en = acc && req.wr;
  assign ofs = {req.addr[11:2], 2'b00};
  assign mapped = (ofs <= PMOD_OFS);

  logic [15:0] rld_ff;
  logic [5:0] usr_pw_ff;
  logic lock_ff;
  logic armed_ff;
  logic [7:0] win_ff;
  logic dis_ff;
  logic slow_ff;
  logic [15:0] cnt_ff;
  logic pre_ff;
  logic wd_rst_seen_ff;
  logic hold_ff;
  logic sys_rst_ff;
  logic [NEV-1:0] sts_ff;
  logic [NEV-1:0] msk_ff;
  logic [1:0] nmi_sync_ff;
  logic nmi_old_ff;
  wdg_pm_t pm_ff;
  logic tick;

  function automatic logic pw_ok(input logic [31:0] d, input logic [5:0] up);
    return d[PW_MSB:PW_LSB] == {FIX_PW, up};
  endfunction

  // ==========================================
  // Service access sequence
  logic con0_wr;
  logic bad_pw;
  logic bad_guard;
  logic timeout;
  logic acc_err;
  logic good_svc;
  assign con0_wr = wr_en && ofs == CON0_OFS;
  assign bad_pw = con0_wr && !armed_ff && !pw_ok(req.wdata, usr_pw_ff);
  assign bad_guard = con0_wr && armed_ff && !req.wdata[GUARD_BIT];
  assign timeout = armed_ff && win_ff == 8'(ACC_WIN_CYC);
  assign acc_err = bad_pw || bad_guard || timeout;
  assign good_svc = con0_wr && armed_ff && req.wdata[GUARD_BIT] && !timeout;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      armed_ff <= 1'b0;
      win_ff <= '0;
    end else if (acc_err || good_svc) begin
      armed_ff <= 1'b0;
      win_ff <= '0;
    end else if (con0_wr) begin
      armed_ff <= 1'b1;
      win_ff <= '0;
    end else if (armed_ff) begin
      win_ff <= win_ff + 1'b1;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rld_ff <= RLD_RST;
      usr_pw_ff <= USR_PW_RST;
      lock_ff <= 1'b1;
    end else if (good_svc) begin
      rld_ff <= req.wdata[31:RLD_LSB];
      usr_pw_ff <= req.wdata[PW_LSB+5:PW_LSB];
      lock_ff <= req.wdata[LOCK_BIT];
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      dis_ff <= 1'b0;
      slow_ff <= 1'b1;
    end else if (wr_en && ofs == CON1_OFS && !lock_ff) begin
      dis_ff <= req.wdata[DIS_BIT];
      slow_ff <= req.wdata[SLOW_BIT];
    end
  end

  // ==========================================
  // Counter and prewarning
  wdg_div #(.SLOW(SLOW_DIV), .FAST(FAST_DIV)) u_div (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_sel_slow(slow_ff),
    .o_tick(tick)
  );

  logic ovf;
  logic err_start;
  assign ovf = tick && cnt_ff == 16'hFFFF && !pre_ff;
  assign err_start = !pre_ff && (acc_err || (ovf && !dis_ff));

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cnt_ff <= RLD_RST;
    end else if (err_start) begin
      cnt_ff <= FIX_RLD;
    end else if (good_svc && !pre_ff) begin
      cnt_ff <= req.wdata[31:RLD_LSB];
    end else if (tick && !(dis_ff && !pre_ff)) begin
      cnt_ff <= (cnt_ff == 16'hFFFF) ? rld_ff : cnt_ff + 1'b1;
    end
  end

  logic pre_done;
  assign pre_done = pre_ff && tick && cnt_ff == 16'hFFFF;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pre_ff <= 1'b0;
    end else if (err_start) begin
      pre_ff <= 1'b1;
    end else if (pre_done) begin
      pre_ff <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      wd_rst_seen_ff <= 1'b0;
      hold_ff <= 1'b0;
      sys_rst_ff <= 1'b0;
    end else begin
      sys_rst_ff <= pre_done || hold_ff;
      if (pre_done) begin
        wd_rst_seen_ff <= 1'b1;
        if (wd_rst_seen_ff) begin
          hold_ff <= 1'b1;
        end
      end
    end
  end

  // ==========================================
  // Power mode and wake
  logic nmi_fall;
  logic cnt_wake;
  assign nmi_fall = nmi_old_ff && !nmi_sync_ff[1];
  assign cnt_wake = tick && cnt_ff == WAKE_FROM && !(dis_ff && !pre_ff) && !err_start;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      nmi_sync_ff <= 2'b11;
      nmi_old_ff <= 1'b1;
    end else begin
      nmi_sync_ff <= {nmi_sync_ff[0], I_NMI_PIN};
      nmi_old_ff <= nmi_sync_ff[1];
    end
  end

  logic wake_ev;
  assign wake_ev = cnt_wake || err_start || nmi_fall || I_IRQ_PEND;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pm_ff <= PM_RUN;
    end else begin
      case (pm_ff)
        PM_RUN: begin
          if (wr_en && ofs == PMOD_OFS && req.wdata[1:0] == 2'd1) begin
            pm_ff <= PM_IDLE;
          end else if (wr_en && ofs == PMOD_OFS && req.wdata[1:0] == 2'd2) begin
            pm_ff <= PM_SLEEP;
          end
        end
        PM_IDLE, PM_SLEEP: begin
          if (wake_ev) begin
            pm_ff <= PM_RUN;
          end
        end
        default: begin
          pm_ff <= PM_RUN;
        end
      endcase
    end
  end

  // ==========================================
  // Interrupt status, set wins over clear
  logic [NEV-1:0] ev;
  assign ev = {cnt_wake, err_start, ovf, acc_err};
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      sts_ff <= '0;
    end else if (wr_en && ofs == IRQS_OFS) begin
      sts_ff <= (sts_ff & ~req.wdata[NEV-1:0]) | ev;
    end else begin
      sts_ff <= sts_ff | ev;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      msk_ff <= '0;
    end else if (wr_en && ofs == IRQM_OFS) begin
      msk_ff <= req.wdata[NEV-1:0];
    end
  end

  // ==========================================
  // Registered outputs
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= '0;
    end else begin
      O_PREADY <= acc;
      O_PSLVERR <= acc && !mapped;
      O_PRDATA <= '0;
      if (acc && !req.wr) begin
        case (ofs)
          CON0_OFS: O_PRDATA <= {rld_ff, FIX_PW, usr_pw_ff, armed_ff, lock_ff};
          CON1_OFS: O_PRDATA <= {30'h0000_0000, slow_ff, dis_ff};
          STAT_OFS: O_PRDATA <= {cnt_ff, 8'h00, 4'h0, hold_ff, wd_rst_seen_ff,
                                 pre_ff, dis_ff};
          IRQS_OFS: O_PRDATA <= {28'h000_0000, sts_ff};
          IRQM_OFS: O_PRDATA <= {28'h000_0000, msk_ff};
          PMOD_OFS: O_PRDATA <= {30'h0000_0000, pm_ff};
          default: O_PRDATA <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_LOCK <= 1'b1;
      O_PROT_WR_OK <= 1'b0;
      O_NMI <= 1'b0;
      O_SYS_RST <= 1'b0;
      O_WAKE <= 1'b0;
      O_IRQ <= 1'b0;
    end else begin
      O_LOCK <= lock_ff;
      O_PROT_WR_OK <= I_SUPERVISOR && !lock_ff;
      O_NMI <= pre_ff;
      O_SYS_RST <= sys_rst_ff;
      O_WAKE <= (pm_ff != PM_RUN) && wake_ev;
      O_IRQ <= |(sts_ff & msk_ff);
    end
  end

  // ==========================================
  // Assertions
  prot_line_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    O_PROT_WR_OK |-> ($past(I_SUPERVISOR) && !$past(lock_ff)))
    else $error("protect line open while locked");
  nmi_first_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    $rose(sys_rst_ff) && !$past(hold_ff) |-> $past(pre_ff))
    else $error("reset without prewarning");
  err_pre_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (bad_pw || bad_guard) && !pre_ff |=> pre_ff ##1 O_NMI)
    else $error("access error did not start prewarning");
  win_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    $rose(armed_ff) |-> ##[1:5] !armed_ff)
    else $error("service window not bounded");
  ovf_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    ovf && !dis_ff |=> pre_ff && cnt_ff == FIX_RLD)
    else $error("overflow did not start prewarning");
  dis_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    dis_ff && !pre_ff && !acc_err && !good_svc |=> $stable(cnt_ff))
    else $error("disabled counter moved");
  hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    hold_ff |=> hold_ff && sys_rst_ff)
    else $error("double reset hold released");
  reload_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    good_svc && !pre_ff && !err_start |=> cnt_ff == $past(req.wdata[31:16]))
    else $error("service did not reload");
  con1_lock_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    wr_en && ofs == CON1_OFS && lock_ff |=> $stable(dis_ff) && $stable(slow_ff))
    else $error("control write passed the lock");
  fix_rld_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    err_start |=> cnt_ff == FIX_RLD)
    else $error("prewarning reload not fixed");
  wake_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    cnt_wake && pm_ff != PM_RUN |=> pm_ff == PM_RUN && O_WAKE)
    else $error("count wake missed");
  svc_c: cover property (@(posedge I_CLK) disable iff (I_RST) good_svc);
  pre_c: cover property (@(posedge I_CLK) disable iff (I_RST) $rose(pre_ff));
  rst_c: cover property (@(posedge I_CLK) disable iff (I_RST) $rose(O_SYS_RST));
  wake_c: cover property (@(posedge I_CLK) disable iff (I_RST) O_WAKE);
endmodule

/* File: wdg_cpu_model.sv */
`timescale 1ns/100ps
module wdg_cpu_model
  import wdg_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // APB answer
  input wire logic i_pready,
  input wire logic i_pslverr,
  input wire logic [31:0] i_prdata,
  // APB request
  output logic o_psel,
  output logic o_penable,
  output wdg_req_t o_req
);
  // ==========================================
  // Bus cycle
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_req = '0;
  end

  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_req <= '{addr: a, wr: w, wdata: d};
    @(posedge i_clk);
    o_penable <= 1'b1;
    do @(posedge i_clk); while (i_pready !== 1'b1);
    q = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // Released bus must not keep showing the last request
    o_req <= '{addr: ~a, wr: ~w, wdata: ~d};
  endtask

  // ==========================================
  // Service sequence
  // two consecutive writes
  task automatic service(input logic [15:0] rld, input logic lock, input logic [5:0] upw);
    logic [31:0] q;
    logic e;
    xfer(CON0_OFS, 1'b1, {16'h0000, FIX_PW, upw, 2'b00}, q, e);
    xfer(CON0_OFS, 1'b1, {rld, FIX_PW, upw, 1'b1, lock}, q, e);
  endtask
endmodule

/* File: tb.sv */
`timescale 1ns/100ps
module tb
  import wdg_pkg::*;
;
  logic I_CLK = 1'b0;
  logic I_RST = 1'b1;
  logic I_SUPERVISOR = 1'b1;
  logic I_NMI_PIN = 1'b1;
  logic I_IRQ_PEND = 1'b0;
  logic psel, penable;
  wdg_req_t req;
  logic [31:0] O_PRDATA;
  logic O_PREADY, O_PSLVERR, O_PROT_WR_OK, O_LOCK, O_NMI, O_SYS_RST, O_WAKE, O_IRQ;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] q;
  logic e;

  always #50 I_CLK = ~I_CLK;

  wdg_unit #(.SLOW_DIV(8), .FAST_DIV(4)) i_dut (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(req.wr), .I_PADDR(req.addr), .I_PWDATA(req.wdata),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_SUPERVISOR(I_SUPERVISOR), .I_NMI_PIN(I_NMI_PIN), .I_IRQ_PEND(I_IRQ_PEND),
    .O_PROT_WR_OK(O_PROT_WR_OK), .O_LOCK(O_LOCK), .O_NMI(O_NMI), .O_SYS_RST(O_SYS_RST),
    .O_WAKE(O_WAKE), .O_IRQ(O_IRQ));

  wdg_cpu_model i_cpu (
    .i_clk(I_CLK), .i_pready(O_PREADY), .i_pslverr(O_PSLVERR), .i_prdata(O_PRDATA),
    .o_psel(psel), .o_penable(penable), .o_req(req));

  // ==========================================
  // Helpers
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_cpu.xfer(a, 1'b1, d, q, e);
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: return O_NMI;
      1: return O_SYS_RST;
      2: return O_IRQ;
      default: return O_WAKE;
    endcase
  endfunction

  task automatic wait_hi(input int w, input int lim);
    for (int n = 0; n < lim && sig(w) !== 1'b1; n++) @(posedge I_CLK);
  endtask

  task automatic do_reset();
    @(posedge I_CLK);
    I_RST <= 1'b1;
    I_NMI_PIN <= 1'b1;
    I_IRQ_PEND <= 1'b0;
    I_SUPERVISOR <= 1'b1;
    repeat (8) @(posedge I_CLK);
    I_RST <= 1'b0;
  endtask

  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ==========================================
  // Scenarios
  task automatic t_lock();
    do_reset();
    check("lock_rst", O_LOCK, 1'b1);
    check("prot_rst", O_PROT_WR_OK, 1'b0);
    wr(CON1_OFS, 32'h0000_0001);
    i_cpu.xfer(CON1_OFS, 1'b0, 32'h0000_0000, q, e);
    check("con1_lock", q, 32'h0000_0002);
    i_cpu.service(16'h1000, 1'b0, 6'h00);
    repeat (2) @(posedge I_CLK);
    check("prot_open", O_PROT_WR_OK, 1'b1);
    check("lock_clr", O_LOCK, 1'b0);
    I_SUPERVISOR <= 1'b0;
    repeat (3) @(posedge I_CLK);
    check("prot_user", O_PROT_WR_OK, 1'b0);
    i_cpu.xfer(STAT_OFS, 1'b0, 32'h0000_0000, q, e);
    check("count_near", 32'(q[31:16] >= 16'h1000 && q[31:16] < 16'h1008), 1);
    check("no_err", O_NMI, 1'b0);
    i_cpu.xfer(12'h020, 1'b0, 32'h0000_0000, q, e);
    check("unmapped", e, 1'b1);
    $display("test lock done");
  endtask

  task automatic t_timeout();
    do_reset();
    i_cpu.service(16'hFFF0, 1'b0, 6'h00);
    wr(CON1_OFS, 32'h0000_0000);
    wait_hi(0, 400);
    check("nmi_ovf", O_NMI, 1'b1);
    check("rst_late", O_SYS_RST, 1'b0);
    wait_hi(1, 100);
    check("rst_first", O_SYS_RST, 1'b1);
    for (int n = 0; n < 20 && O_SYS_RST !== 1'b0; n++) @(posedge I_CLK);
    wait_hi(1, 400);
    repeat (20) @(posedge I_CLK);
    check("rst_hold", O_SYS_RST, 1'b1);
    do_reset();
    @(posedge I_CLK);
    check("rst_clear", O_SYS_RST, 1'b0);
    $display("test timeout done");
  endtask

  task automatic t_disable();
    do_reset();
    i_cpu.service(16'hFFF0, 1'b0, 6'h00);
    wr(CON1_OFS, 32'h0000_0003);
    repeat (300) @(posedge I_CLK);
    check("dis_quiet", O_NMI, 1'b0);
    i_cpu.xfer(STAT_OFS, 1'b0, 32'h0000_0000, q, e);
    check("dis_stat", q[3:0], 4'h1);
    wr(CON0_OFS, 32'h0000_1100);
    wait_hi(0, 20);
    check("dis_pw", O_NMI, 1'b1);
    $display("test disable done");
  endtask

  task automatic t_access();
    do_reset();
    // user password changed by a service
    wr(CON0_OFS, {16'h0000, FIX_PW, 6'h00, 2'b00});
    wr(CON0_OFS, {16'h1000, FIX_PW, 6'h15, 2'b10});
    wr(IRQM_OFS, 32'h0000_0001);
    wr(CON0_OFS, {16'h0000, FIX_PW, 6'h00, 2'b00});
    wait_hi(2, 10);
    check("irq_pw", O_IRQ, 1'b1);
    i_cpu.xfer(IRQS_OFS, 1'b0, 32'h0000_0000, q, e);
    check("irq_stat", q[EV_ACC], 1'b1);
    wr(IRQS_OFS, 32'h0000_0001);
    repeat (2) @(posedge I_CLK);
    check("irq_clr", O_IRQ, 1'b0);
    do_reset();
    i_cpu.service(16'h1000, 1'b0, 6'h00);
    wr(CON0_OFS, {16'h1000, FIX_PW, 6'h00, 2'b00});
    wr(CON0_OFS, {16'h1000, FIX_PW, 6'h00, 2'b00});
    wait_hi(0, 20);
    check("guard", O_NMI, 1'b1);
    do_reset();
    i_cpu.service(16'h1000, 1'b0, 6'h00);
    wr(CON0_OFS, {16'h0000, FIX_PW, 6'h00, 2'b00});
    repeat (6) @(posedge I_CLK);
    wr(CON0_OFS, {16'h1000, FIX_PW, 6'h00, 2'b10});
    wait_hi(0, 20);
    check("window", O_NMI, 1'b1);
    $display("test access done");
  endtask

  task automatic t_wake();
    do_reset();
    i_cpu.service(16'h7FFE, 1'b0, 6'h00);
    wr(PMOD_OFS, 32'h0000_0001);
    wait_hi(3, 60);
    check("wake_cnt", O_WAKE, 1'b1);
    @(posedge I_CLK);
    i_cpu.xfer(PMOD_OFS, 1'b0, 32'h0000_0000, q, e);
    check("run_mode", q[1:0], 2'(PM_RUN));
    wr(PMOD_OFS, 32'h0000_0002);
    I_IRQ_PEND <= 1'b1;
    wait_hi(3, 20);
    check("wake_irq", O_WAKE, 1'b1);
    @(posedge I_CLK);
    I_IRQ_PEND <= 1'b0;
    wr(PMOD_OFS, 32'h0000_0001);
    I_NMI_PIN <= 1'b0;
    wait_hi(3, 20);
    check("wake_pin", O_WAKE, 1'b1);
    $display("test wake done");
  endtask

  initial begin
    t_lock();
    t_timeout();
    t_disable();
    t_access();
    t_wake();
    print_verdict();
  end
endmodule
